// *** rtl/uart_irq_map.svh ***
// register offsets, field positions and reset values of the interrupt-clear and identification bank
`ifndef UART_IRQ_MAP_SVH
`define UART_IRQ_MAP_SVH

// ============================================================
// register offsets (byte addresses)
`define OFS_IRQ_MASK      12'h038
`define OFS_IRQ_RAW       12'h03C
`define OFS_IRQ_MASKED    12'h040
`define OFS_IRQ_CLEAR     12'h044
`define OFS_ID_BYTE_LOW   12'hFD0
`define OFS_ID_BYTE_SEC   12'hFD4
`define OFS_ID_BYTE_THIRD 12'hFD8

// ============================================================
// field positions inside the status, mask, clear and identification words
`define BIT_FRAMING_ERR   7
`define BIT_RX_TIMEOUT    6
`define BIT_TX_IRQ        5
`define BIT_RX_IRQ        4
`define IRQ_FIELD_MSB     7
`define IRQ_FIELD_LSB     4
`define ID_FIELD_MSB      7
`define ID_FIELD_LSB      0

// ============================================================
// reset values
`define RST_IRQ_VEC       4'h0
`define RST_WORD          32'h0000_0000

`endif

// *** rtl/uart_irq_pkg.sv ***
// types shared by the interrupt-clear and identification bank
package uart_irq_pkg;

	// one bit per event: 3 framing error, 2 receive time-out, 1 transmit, 0 receive
	typedef logic [3:0]  irq_vec_t;
	typedef logic [31:0] word_t;
	typedef logic [11:0] reg_addr_t;
	typedef logic [7:0]  id_byte_t;

endpackage

// *** rtl/uart_irq_clear_and_id_regs.sv ***
// interrupt-clear register, interrupt status and mask, and read-only identification bytes
`timescale 1ns/1ps
`include "uart_irq_map.svh"

module uart_irq_clear_and_id_regs
	import uart_irq_pkg::*;
#(
	// composite identifier; value is arbitrary
	parameter logic [23:0] IDENT_VALUE = 24'h5A3C96
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        ev_framing_error,
	input  wire logic        ev_rx_timeout,
	input  wire logic        ev_tx,
	input  wire logic        ev_rx,
	output logic      [3:0]  raw_status,
	output logic      [3:0]  masked_status,
	output logic             irq
);

	// ============================================================
	// address decode
	function automatic logic hit(input reg_addr_t a, input reg_addr_t ofs);
		hit = (a == ofs);
	endfunction

	wire logic sel_mask   = hit(reg_addr, `OFS_IRQ_MASK);
	wire logic sel_raw    = hit(reg_addr, `OFS_IRQ_RAW);
	wire logic sel_masked = hit(reg_addr, `OFS_IRQ_MASKED);
	wire logic sel_clear  = hit(reg_addr, `OFS_IRQ_CLEAR);
	wire logic sel_id_lo  = hit(reg_addr, `OFS_ID_BYTE_LOW);
	wire logic sel_id_sec = hit(reg_addr, `OFS_ID_BYTE_SEC);
	wire logic sel_id_thr = hit(reg_addr, `OFS_ID_BYTE_THIRD);
	wire logic sel_id     = sel_id_lo | sel_id_sec | sel_id_thr;

	// ============================================================
	// identification bytes, hard-wired
	wire id_byte_t ident_byte_low    = IDENT_VALUE[7:0];
	wire id_byte_t ident_byte_second = IDENT_VALUE[15:8];
	wire id_byte_t ident_byte_third  = IDENT_VALUE[23:16];

	// ============================================================
	// interrupt status and mask
	irq_vec_t raw_q;
	irq_vec_t raw_d;
	irq_vec_t mask_q;
	irq_vec_t mask_d;
	irq_vec_t event_vec;
	irq_vec_t clear_vec;

	assign event_vec = {ev_framing_error, ev_rx_timeout, ev_tx, ev_rx};

	// only bits 7..4 act; bits 3..0 of a clear write are dropped
	assign clear_vec = {reg_wr & sel_clear & reg_wdata[`BIT_FRAMING_ERR],
	                    reg_wr & sel_clear & reg_wdata[`BIT_RX_TIMEOUT],
	                    reg_wr & sel_clear & reg_wdata[`BIT_TX_IRQ],
	                    reg_wr & sel_clear & reg_wdata[`BIT_RX_IRQ]};

	// set beats clear, so an event in the clearing cycle is kept
	assign raw_d  = (raw_q & ~clear_vec) | event_vec;
	assign mask_d = (reg_wr & sel_mask) ? reg_wdata[`IRQ_FIELD_MSB:`IRQ_FIELD_LSB] : mask_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			raw_q  <= `RST_IRQ_VEC;
			mask_q <= `RST_IRQ_VEC;
		end else begin
			raw_q  <= raw_d;
			mask_q <= mask_d;
		end
	end

	// masked view derives from raw, so one clear drops both
	assign raw_status    = raw_q;
	assign masked_status = raw_q & mask_q;
	assign irq           = |masked_status;

	// ============================================================
	// read word packing; fields sit at fixed positions, every other bit reads zero
	function automatic word_t status_word(input irq_vec_t v);
		status_word = word_t'(v) << `IRQ_FIELD_LSB;
	endfunction

	function automatic word_t id_word(input id_byte_t b);
		id_word = word_t'(b) << `ID_FIELD_LSB;
	endfunction

	// ============================================================
	// read path, data valid the cycle after the strobe only
	word_t rd_mux;
	word_t rdata_q;

	assign rd_mux = sel_mask   ? status_word(mask_q) :
	                sel_raw    ? status_word(raw_q) :
	                sel_masked ? status_word(masked_status) :
	                sel_id_lo  ? id_word(ident_byte_low) :
	                sel_id_sec ? id_word(ident_byte_second) :
	                sel_id_thr ? id_word(ident_byte_third) :
	                `RST_WORD;                                   // clear reads zero

	// id writes decode nowhere, so they change nothing
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= `RST_WORD;
		end else begin
			rdata_q <= reg_rd ? rd_mux : `RST_WORD;
		end
	end

	assign reg_rdata = rdata_q;

	// ============================================================
	// assertions
	a_fe_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_clear && reg_wdata[7] && !ev_framing_error |=> !raw_status[3])
		else $error("framing error not cleared");

	a_fe_zero_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_clear && !reg_wdata[7] && raw_status[3] |=> raw_status[3])
		else $error("framing error lost on zero write");

	a_rt_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_clear && reg_wdata[6] && !ev_rx_timeout |=> !raw_status[2])
		else $error("receive time-out not cleared");

	a_rt_zero_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_clear && !reg_wdata[6] && raw_status[2] |=> raw_status[2])
		else $error("receive time-out lost on zero write");

	a_tx_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_clear && reg_wdata[5] && !ev_tx |=> !raw_status[1])
		else $error("transmit interrupt not cleared");

	a_tx_zero_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_clear && !reg_wdata[5] && raw_status[1] |=> raw_status[1])
		else $error("transmit interrupt lost on zero write");

	a_rx_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_clear && reg_wdata[4] && !ev_rx |=> !raw_status[0])
		else $error("receive interrupt not cleared");

	a_rx_zero_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_clear && !reg_wdata[4] && raw_status[0] |=> raw_status[0])
		else $error("receive interrupt lost on zero write");

	a_clear_reads_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && sel_clear |=> reg_rdata == 32'h0000_0000)
		else $error("clear register read not zero");

	a_id_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && sel_id |=> reg_rdata[31:8] == 24'h00_0000)
		else $error("identification upper bits not zero");

	a_id_low_byte: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && sel_id_lo |=> reg_rdata[7:0] == IDENT_VALUE[7:0])
		else $error("identifier bits 7..0 wrong");

	a_id_second_byte: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && sel_id_sec |=> reg_rdata[7:0] == IDENT_VALUE[15:8])
		else $error("identifier bits 15..8 wrong");

	a_id_third_byte: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && sel_id_thr |=> reg_rdata[7:0] == IDENT_VALUE[23:16])
		else $error("identifier bits 23..16 wrong");

	a_masked_clear_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_clear && (reg_wdata[7:4] == 4'hF) && (event_vec == 4'h0)
		|=> !irq && masked_status == 4'h0 && raw_status == 4'h0)
		else $error("clear left masked status or irq");

	a_masked_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ev_framing_error && mask_q[3] && !(reg_wr && sel_mask) |=> masked_status[3] && irq)
		else $error("enabled event not seen in masked status");

	a_id_write_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_id ##1 reg_rd && sel_id_lo |=> reg_rdata == {24'h00_0000, IDENT_VALUE[7:0]})
		else $error("identification write changed read value");

	a_read_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside its cycle");

	a_fe_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ev_framing_error |=> raw_status[3])
		else $error("framing error event not latched");

	a_rt_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ev_rx_timeout |=> raw_status[2])
		else $error("receive time-out event not latched");

	a_tx_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ev_tx |=> raw_status[1])
		else $error("transmit event not latched");

	a_rx_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ev_rx |=> raw_status[0])
		else $error("receive event not latched");

	a_fe_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(reg_wr && sel_clear) && raw_status[3] |=> raw_status[3])
		else $error("framing error dropped without a clear");

	a_rt_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(reg_wr && sel_clear) && raw_status[2] |=> raw_status[2])
		else $error("receive time-out dropped without a clear");

	a_tx_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(reg_wr && sel_clear) && raw_status[1] |=> raw_status[1])
		else $error("transmit interrupt dropped without a clear");

	a_rx_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(reg_wr && sel_clear) && raw_status[0] |=> raw_status[0])
		else $error("receive interrupt dropped without a clear");

	a_fe_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!raw_status[3] && !ev_framing_error |=> !raw_status[3])
		else $error("framing error set without an event");

	a_rt_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!raw_status[2] && !ev_rx_timeout |=> !raw_status[2])
		else $error("receive time-out set without an event");

	a_tx_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!raw_status[1] && !ev_tx |=> !raw_status[1])
		else $error("transmit interrupt set without an event");

	a_rx_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!raw_status[0] && !ev_rx |=> !raw_status[0])
		else $error("receive interrupt set without an event");

	a_fe_masked_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_clear && reg_wdata[7] && !ev_framing_error |=> !masked_status[3])
		else $error("masked framing error not cleared");

	a_rt_masked_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_clear && reg_wdata[6] && !ev_rx_timeout |=> !masked_status[2])
		else $error("masked receive time-out not cleared");

	a_tx_masked_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_clear && reg_wdata[5] && !ev_tx |=> !masked_status[1])
		else $error("masked transmit interrupt not cleared");

	a_rx_masked_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_clear && reg_wdata[4] && !ev_rx |=> !masked_status[0])
		else $error("masked receive interrupt not cleared");

	a_rt_masked_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ev_rx_timeout && mask_q[2] && !(reg_wr && sel_mask) |=> masked_status[2] && irq)
		else $error("enabled receive time-out not seen in masked status");

	a_tx_masked_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ev_tx && mask_q[1] && !(reg_wr && sel_mask) |=> masked_status[1] && irq)
		else $error("enabled transmit event not seen in masked status");

	a_rx_masked_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ev_rx && mask_q[0] && !(reg_wr && sel_mask) |=> masked_status[0] && irq)
		else $error("enabled receive event not seen in masked status");

	a_reserved_clear_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_clear && reg_wdata[7:4] == 4'h0 && event_vec == 4'h0 |=> raw_status == $past(raw_status))
		else $error("reserved clear bits changed status");

	a_id_low_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && sel_id_lo |=> reg_rdata == {24'h00_0000, IDENT_VALUE[7:0]})
		else $error("identifier low word wrong");

	a_id_second_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && sel_id_sec |=> reg_rdata == {24'h00_0000, IDENT_VALUE[15:8]})
		else $error("identifier second word wrong");

	a_id_third_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && sel_id_thr |=> reg_rdata == {24'h00_0000, IDENT_VALUE[23:16]})
		else $error("identifier third word wrong");

	a_id_write_second: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_id ##1 reg_rd && sel_id_sec |=> reg_rdata == {24'h00_0000, IDENT_VALUE[15:8]})
		else $error("identification write changed second word");

	a_id_write_third: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_id ##1 reg_rd && sel_id_thr |=> reg_rdata == {24'h00_0000, IDENT_VALUE[23:16]})
		else $error("identification write changed third word");

	a_id_write_raw: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_id && event_vec == 4'h0 |=> raw_status == $past(raw_status))
		else $error("identification write changed status");

	a_id_write_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_id |=> mask_q == $past(mask_q))
		else $error("identification write changed mask");

	a_mask_read_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && sel_mask |=> reg_rdata == {24'h00_0000, $past(mask_q), 4'h0})
		else $error("mask read word wrong");

	a_raw_read_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && sel_raw |=> reg_rdata == {24'h00_0000, $past(raw_status), 4'h0})
		else $error("raw status read word wrong");

	a_masked_read_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && sel_masked |=> reg_rdata == {24'h00_0000, $past(masked_status), 4'h0})
		else $error("masked status read word wrong");

	a_mask_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_mask |=> mask_q == $past(reg_wdata[7:4]))
		else $error("mask write not taken");

	a_mask_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(reg_wr && sel_mask) |=> $stable(mask_q))
		else $error("mask changed without a write");

	a_unmapped_read_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && !sel_mask && !sel_raw && !sel_masked && !sel_id |=> reg_rdata == 32'h0000_0000)
		else $error("unmapped or clear read not zero");

	a_status_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && !sel_id |=> reg_rdata[31:8] == 24'h00_0000 && reg_rdata[3:0] == 4'h0)
		else $error("reserved status bits not zero");

	a_status_write_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && (sel_raw || sel_masked) && event_vec == 4'h0 |=> raw_status == $past(raw_status))
		else $error("status register write changed status");

	a_irq_masked_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && sel_mask && reg_wdata[7:4] == 4'h0 |=> !irq)
		else $error("irq high with every source masked");

	a_irq_mask_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
		raw_status[0] && reg_wr && sel_mask && reg_wdata[4] |=> irq)
		else $error("irq not raised when a pending source is enabled");

endmodule

// *** test/uart_irq_clear_and_id_regs_bench.sv ***
// self-checking bench for the interrupt-clear and identification bank
`timescale 1ns/1ps
`include "uart_irq_map.svh"

module uart_irq_clear_and_id_regs_bench import uart_irq_pkg::*;;
	// ============================================================
	// stimulus and observation
	// arbitrary identifier, not the default, so the parameter is seen to reach the outputs
	localparam logic [23:0] IDENT = 24'hC3A512;
	logic      clk_sys = 1'b0;
	logic      rst_n   = 1'b0;
	reg_addr_t reg_addr;
	word_t     reg_wdata;
	logic      reg_wr;
	logic      reg_rd;
	word_t     reg_rdata;
	irq_vec_t  ev;
	irq_vec_t  raw_status;
	irq_vec_t  masked_status;
	logic      irq;
	word_t     got;
	int        failures    = 0;
	int        comparisons = 0;

	always #5 clk_sys = ~clk_sys;

	uart_irq_clear_and_id_regs #(.IDENT_VALUE(IDENT)) dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ev_framing_error(ev[3]), .ev_rx_timeout(ev[2]), .ev_tx(ev[1]), .ev_rx(ev[0]),
		.raw_status(raw_status), .masked_status(masked_status), .irq(irq));

	`define CHECK(what, exp, seen) begin comparisons++; if ((seen) !== (exp)) begin failures++; \
		$display("BAD %s expected %0h seen %0h", what, exp, seen); end end

	// ============================================================
	// bus and event tasks
	task automatic wr(input reg_addr_t a, input word_t d);
		@(posedge clk_sys); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge clk_sys); reg_wr <= 1'b0;
		#1;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input reg_addr_t a, output word_t d);
		@(posedge clk_sys); reg_addr <= a; reg_rd <= 1'b1;
		@(posedge clk_sys); reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// write then read with no idle cycle between the strobes
	task automatic wr_rd(input reg_addr_t a, input word_t d, output word_t q);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask
	task automatic fire(input irq_vec_t v);
		@(posedge clk_sys); ev <= v;
		@(posedge clk_sys); ev <= 4'h0;
		#1;
	endtask

	// ============================================================
	// scenarios
	task automatic check_reset;
		for (int i = 0; i < 4; i++) begin
			rd(`OFS_IRQ_MASK + 12'(4 * i), got);
			`CHECK("reset word", 32'h0000_0000, got)
		end
		`CHECK("irq after reset", 1'b0, irq)
	endtask
	task automatic check_ids;
		for (int i = 0; i < 3; i++) begin
			rd(`OFS_ID_BYTE_LOW + 12'(4 * i), got);
			`CHECK("id byte", {24'h0, IDENT[8 * i +: 8]}, got)
			@(posedge clk_sys); #1;
			`CHECK("rdata idle", 32'h0000_0000, reg_rdata)
			wr_rd(`OFS_ID_BYTE_LOW + 12'(4 * i), 32'hFFFF_FFFF, got);
			`CHECK("id after write", {24'h0, IDENT[8 * i +: 8]}, got)
		end
		rd(12'h100, got);
		`CHECK("unmapped read", 32'h0000_0000, got)
	endtask
	// each clear bit alone, with the read-only bits 3..0 written as ones
	task automatic check_clear;
		irq_vec_t e;
		wr(`OFS_IRQ_MASK, 32'h0000_00F0);
		for (int b = 0; b < 4; b++) begin
			e = 4'hF & ~(4'h1 << b);
			fire(4'hF);
			`CHECK("raw set", 4'hF, raw_status)
			rd(`OFS_IRQ_RAW, got);
			`CHECK("raw word", {24'h0, 4'hF, 4'h0}, got)
			wr(`OFS_IRQ_CLEAR, 32'h0000_000F | (32'h0000_0010 << b));
			`CHECK("raw after clear", e, raw_status)
			`CHECK("masked after clear", e, masked_status)
			rd(`OFS_IRQ_MASKED, got);
			`CHECK("masked word", {24'h0, e, 4'h0}, got)
			rd(`OFS_IRQ_CLEAR, got);
			`CHECK("clear reads zero", 32'h0000_0000, got)
		end
		wr(`OFS_IRQ_CLEAR, 32'h0000_000F);
		`CHECK("reserved bits only", 4'h7, raw_status)
		wr(`OFS_IRQ_CLEAR, 32'h0000_00F0);
		`CHECK("all cleared", 4'h0, raw_status)
		`CHECK("irq dropped", 1'b0, irq)
	endtask
	// a masked event stays raw only; enabling it raises irq until it is cleared
	task automatic check_mask;
		wr(`OFS_IRQ_MASK, 32'h0000_0000);
		fire(4'h1);
		`CHECK("raw rx", 4'h1, raw_status)
		`CHECK("irq masked", 1'b0, irq)
		wr(`OFS_IRQ_RAW, 32'h0000_0000);
		`CHECK("raw after status write", 4'h1, raw_status)
		wr(`OFS_IRQ_MASK, 32'h0000_0010);
		`CHECK("irq enabled", 1'b1, irq)
		rd(`OFS_IRQ_MASK, got);
		`CHECK("mask word", 32'h0000_0010, got)
		wr(`OFS_IRQ_CLEAR, 32'h0000_0010);
		`CHECK("masked rx cleared", 4'h0, masked_status)
		`CHECK("irq cleared", 1'b0, irq)
	endtask
	// an event in the very cycle of its clear is kept
	task automatic check_set_wins;
		@(posedge clk_sys);
		ev        <= 4'h8;
		reg_addr  <= `OFS_IRQ_CLEAR;
		reg_wdata <= 32'h0000_00F0;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		ev     <= 4'h0;
		reg_wr <= 1'b0;
		#1;
		`CHECK("event beats clear", 4'h8, raw_status)
		wr(`OFS_IRQ_CLEAR, 32'h0000_0080);
		`CHECK("framing cleared", 4'h0, raw_status)
	endtask

	// ============================================================
	// sequence, watchdog and verdict
	task automatic test_done;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		reg_addr  = 12'h000;
		reg_wdata = 32'h0000_0000;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		ev        = 4'h0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		check_reset;
		check_ids;
		check_clear;
		check_mask;
		check_set_wins;
		test_done;
	end

	// the tests need well under a thousand cycles
	initial begin
		#20000;
		failures++;
		test_done;
	end
endmodule
